// *** rtl/eag_pkg.sv ***
// Package of the effective address generator: modes, carriers and constants.
// Assumes one clock domain shared with the core that issues requests.
package eag_pkg;

  typedef enum logic [4:0] {
    MODE_IMM, MODE_ACC, MODE_IMPL, MODE_ABS, MODE_ABS_LONG, MODE_DIR,
    MODE_DIR_IND_IDX_Y, MODE_DIR_IND_LONG_IDX_Y, MODE_DIR_IDX_IND_X,
    MODE_DIR_X, MODE_DIR_Y, MODE_ABS_X, MODE_ABS_Y, MODE_ABS_LONG_X,
    MODE_REL, MODE_REL_LONG, MODE_ABS_IND, MODE_ABS_IND_LONG,
    MODE_DIR_IND, MODE_DIR_IND_LONG, MODE_ABS_IDX_IND
  } addr_mode_t;

  typedef enum logic [1:0] {OPSZ_8, OPSZ_16, OPSZ_32} op_size_t;

  typedef enum logic [1:0] {SRC_MEMORY, SRC_IMMEDIATE, SRC_ACCUM, SRC_IMPLIED} operand_src_t;

  typedef struct packed {
    logic       valid;
    addr_mode_t mode;
    op_size_t   size;
    logic       native;
    logic       push_rel;
    logic [7:0] byte2;
    logic [7:0] byte3;
    logic [7:0] byte4;
    logic [7:0] byte5;
  } ea_req_t;

  typedef struct packed {
    logic [15:0] direct_base;
    logic [7:0]  data_bank_base;
    logic [7:0]  program_bank_base;
    logic [15:0] pc_next;
    logic [31:0] index_x;
    logic [31:0] index_y;
  } cpu_regs_t;

  typedef struct packed {
    logic         valid;
    logic [31:0]  addr;
    operand_src_t src;
    logic [31:0]  imm;
    logic [2:0]   length;
    logic         pc_load;
    logic [15:0]  pc_value;
    logic         pbank_load;
    logic [7:0]   pbank_value;
    logic         push_valid;
    logic [15:0]  push_value;
  } ea_result_t;

  localparam logic [31:0] ADDR24_MASK  = 32'h00FF_FFFF;
  localparam logic [7:0]  BANK_ZERO    = 8'h00;
  localparam logic [7:0]  DL_ZERO      = 8'h00;
  localparam logic [15:0] HALF_ZERO    = 16'h0000;
  localparam logic [1:0]  PTR_BYTES_SHORT = 2'h2;
  localparam logic [1:0]  PTR_BYTES_LONG  = 2'h3;
  localparam int          PTR_BYTES_MAX   = 3;
  localparam logic [2:0]  LEN_ONE   = 3'h1;
  localparam logic [2:0]  LEN_TWO   = 3'h2;
  localparam logic [2:0]  LEN_THREE = 3'h3;
  localparam logic [2:0]  LEN_FOUR  = 3'h4;
  localparam logic [2:0]  LEN_FIVE  = 3'h5;

endpackage

// *** rtl/ptr_fetch.sv ***
// Pointer reader: fetches two or three bytes of a pointer held in bank zero.
// Assumes memory answers each held read request with a one-cycle ack on core_clk.
`timescale 1ns/100ps
module ptr_fetch
  import eag_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        start,
  input  wire logic [15:0] base,
  input  wire logic [1:0]  count,
  input  wire logic [7:0]  rd_data,
  input  wire logic        rd_ack,
  output logic             rd_req,
  output logic [23:0]      rd_addr,
  output logic [23:0]      data,
  output logic             done
);

  logic        rd_req_q;
  logic [15:0] off_q;
  logic [1:0]  idx_q;
  logic [1:0]  count_q;
  logic        done_q;
  logic [7:0]  bytes_q [PTR_BYTES_MAX];
  logic        take;

  assign take = rd_req_q && rd_ack;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_req_q <= 1'b0;
      off_q    <= HALF_ZERO;
      idx_q    <= 2'h0;
      count_q  <= 2'h0;
    end else if (clk_en) begin
      if (start) begin
        rd_req_q <= 1'b1;
        off_q    <= base;
        idx_q    <= 2'h0;
        count_q  <= count;
      end else if (take) begin
        // Pointer bytes wrap inside bank zero
        off_q <= off_q + 16'h0001;
        idx_q <= idx_q + 2'h1;
        if (idx_q == count_q - 2'h1) begin
          rd_req_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= take && (idx_q == count_q - 2'h1);
    end
  end

  for (genvar g = 0; g < PTR_BYTES_MAX; g++) begin : g_byte
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        bytes_q[g] <= 8'h00;
      end else if (clk_en) begin
        // Clearing at start keeps the bank byte zero for short pointers
        if (start) begin
          bytes_q[g] <= 8'h00;
        end else if (take && idx_q == 2'(g)) begin
          bytes_q[g] <= rd_data;
        end
      end
    end
  end

  assign rd_req  = rd_req_q;
  assign rd_addr = {BANK_ZERO, off_q};
  assign data    = {bytes_q[2], bytes_q[1], bytes_q[0]};
  assign done    = done_q;

endmodule

// *** rtl/effective_address_generator.sv ***
// Effective address generator: forms operand and jump addresses per mode.
// Assumes register values stay stable while req.valid is high and are taken
// with the request; pointer memory answers on core_clk.
`timescale 1ns/100ps
// What this block does
// - Immediate operand from bytes two onward by size
// - Absolute: bytes two, three plus data bank
// - Direct: byte two plus direct base, bank zero
// - Extra cycle when direct base low byte nonzero
// - Accumulator and implied instructions are one byte
// - Direct indirect indexed: pointer, data bank, plus Y
// - Direct indirect long indexed: 24-bit pointer plus Y
// - Direct indexed indirect: pointer via X, data bank
// - Direct X: 16-bit sum in bank zero
// - Direct Y: 16-bit sum in bank zero
// - Absolute X: bytes plus X, data bank
// - Absolute Y: bytes plus Y, data bank
// - Absolute long X: 24-bit bytes plus X
// - Short branch adds signed byte to PC
// - Long relative adds signed word; branch or push
// - Absolute indirect: bank-zero pointer loads PC
// - Long jump also loads program bank byte
// - Direct indirect: pointer low bits, data bank
// - Direct indirect long: pointer holds full address
// - Absolute indexed indirect: pointer read at bytes plus X loads PC
// - Absolute indexed and indirect Y-indexed addresses carry across bank boundaries
// - Native starred modes give 32-bit addresses on result.addr
module effective_address_generator
  import eag_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire ea_req_t    req,
  input  wire cpu_regs_t  regs,
  output logic            req_ready,
  input  wire logic [7:0] mem_rd_data,
  input  wire logic       mem_rd_ack,
  output logic            mem_rd_req,
  output logic [23:0]     mem_rd_addr,
  output ea_result_t      result,
  output logic [23:0]     addr_bus,
  output logic            dp_penalty
);

  typedef enum logic [1:0] {S_IDLE, S_PENALTY, S_PTR, S_FINISH} state_t;

  state_t      state_q;
  ea_req_t     req_q;
  cpu_regs_t   regs_q;
  logic        ready_q;
  logic        penalty_q;
  ea_result_t  result_q;
  logic [23:0] addr_bus_q;
  logic        accept;
  logic        indirect;
  logic        ptr_start;
  logic [15:0] ptr_base;
  logic [1:0]  ptr_count;
  logic [23:0] ptr_data;
  logic        ptr_done;
  logic [15:0] dp_sum;
  logic [31:0] idx_x;
  logic [31:0] idx_y;
  logic        starred;
  ea_result_t  res_d;
  logic [31:0] wide_addr;

  assign accept = req.valid && ready_q;

  // Direct base and index are taken from the stored copy
  assign dp_sum = regs_q.direct_base + {BANK_ZERO, req_q.byte2};
  assign idx_x  = req_q.native ? regs_q.index_x : {HALF_ZERO, regs_q.index_x[15:0]};
  assign idx_y  = req_q.native ? regs_q.index_y : {HALF_ZERO, regs_q.index_y[15:0]};

  always_comb begin
    indirect  = 1'b0;
    starred   = 1'b0;
    unique case (req_q.mode)
      MODE_DIR_IND_IDX_Y, MODE_DIR_IND_LONG_IDX_Y, MODE_ABS_X, MODE_ABS_Y,
      MODE_ABS_LONG_X: starred = 1'b1;
      default: ;
    endcase
    unique case (req_q.mode)
      MODE_DIR_IND_IDX_Y, MODE_DIR_IND_LONG_IDX_Y, MODE_DIR_IDX_IND_X, MODE_DIR_IND,
      MODE_DIR_IND_LONG, MODE_ABS_IND, MODE_ABS_IND_LONG, MODE_ABS_IDX_IND: indirect = 1'b1;
      default: ;
    endcase
  end

  always_comb begin
    ptr_count = PTR_BYTES_SHORT;
    ptr_base  = dp_sum;
    unique case (req_q.mode)
      MODE_DIR_IND_LONG_IDX_Y, MODE_DIR_IND_LONG: ptr_count = PTR_BYTES_LONG;
      MODE_DIR_IDX_IND_X: ptr_base = dp_sum + regs_q.index_x[15:0];
      MODE_ABS_IND: ptr_base = {req_q.byte3, req_q.byte2};
      MODE_ABS_IND_LONG: begin
        ptr_base  = {req_q.byte3, req_q.byte2};
        ptr_count = PTR_BYTES_LONG;
      end
      MODE_ABS_IDX_IND: ptr_base = {req_q.byte3, req_q.byte2} + regs_q.index_x[15:0];
      default: ;
    endcase
  end

  // Starting on entry to the pointer state keeps the penalty cycle ahead of the reads
  assign ptr_start = (state_q == S_PTR) && !mem_rd_req && !ptr_done;

  ptr_fetch u_ptr_fetch (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .start    (ptr_start),
    .base     (ptr_base),
    .count    (ptr_count),
    .rd_data  (mem_rd_data),
    .rd_ack   (mem_rd_ack),
    .rd_req   (mem_rd_req),
    .rd_addr  (mem_rd_addr),
    .data     (ptr_data),
    .done     (ptr_done)
  );

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
      ready_q <= 1'b1;
    end else if (clk_en) begin
      unique case (state_q)
        S_IDLE: if (accept) begin
          ready_q <= 1'b0;
          if (req.mode inside {MODE_DIR, MODE_DIR_X, MODE_DIR_Y, MODE_DIR_IND,
              MODE_DIR_IND_LONG, MODE_DIR_IDX_IND_X, MODE_DIR_IND_IDX_Y,
              MODE_DIR_IND_LONG_IDX_Y} && regs.direct_base[7:0] != DL_ZERO) begin
            state_q <= S_PENALTY;
          end else if (req.mode inside {MODE_ABS_IND, MODE_ABS_IND_LONG, MODE_ABS_IDX_IND,
              MODE_DIR_IND_IDX_Y, MODE_DIR_IND_LONG_IDX_Y, MODE_DIR_IDX_IND_X,
              MODE_DIR_IND, MODE_DIR_IND_LONG}) begin
            state_q <= S_PTR;
          end else begin
            state_q <= S_FINISH;
          end
        end
        S_PENALTY: state_q <= indirect ? S_PTR : S_FINISH;
        S_PTR: if (ptr_done) begin
          state_q <= S_FINISH;
        end
        S_FINISH: begin
          state_q <= S_IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_q  <= '0;
      regs_q <= '0;
    end else if (clk_en && accept) begin
      req_q  <= req;
      regs_q <= regs;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      penalty_q <= 1'b0;
    end else if (clk_en) begin
      penalty_q <= (state_q == S_PENALTY);
    end
  end

  always_comb begin
    res_d        = '0;
    res_d.valid  = 1'b1;
    res_d.src    = SRC_MEMORY;
    res_d.length = LEN_TWO;
    wide_addr    = 32'h0000_0000;
    unique case (req_q.mode)
      MODE_IMM: begin
        res_d.src = SRC_IMMEDIATE;
        unique case (req_q.size)
          OPSZ_8: res_d.imm = {24'h000000, req_q.byte2};
          OPSZ_16: begin
            res_d.imm    = {HALF_ZERO, req_q.byte3, req_q.byte2};
            res_d.length = LEN_THREE;
          end
          default: begin
            res_d.imm    = {req_q.byte5, req_q.byte4, req_q.byte3, req_q.byte2};
            res_d.length = LEN_FIVE;
          end
        endcase
      end
      MODE_ACC: begin
        res_d.src    = SRC_ACCUM;
        res_d.length = LEN_ONE;
      end
      MODE_IMPL: begin
        res_d.src    = SRC_IMPLIED;
        res_d.length = LEN_ONE;
      end
      MODE_ABS: begin
        wide_addr    = {BANK_ZERO, regs_q.data_bank_base, req_q.byte3, req_q.byte2};
        res_d.length = LEN_THREE;
      end
      MODE_ABS_LONG: begin
        wide_addr    = {BANK_ZERO, req_q.byte4, req_q.byte3, req_q.byte2};
        res_d.length = LEN_FOUR;
      end
      MODE_DIR: wide_addr = {HALF_ZERO, dp_sum};
      MODE_DIR_X: wide_addr = {HALF_ZERO, 16'(dp_sum + regs_q.index_x[15:0])};
      MODE_DIR_Y: wide_addr = {HALF_ZERO, 16'(dp_sum + regs_q.index_y[15:0])};
      MODE_DIR_IND_IDX_Y:
        wide_addr = {BANK_ZERO, regs_q.data_bank_base, ptr_data[15:0]} + idx_y;
      MODE_DIR_IND_LONG_IDX_Y: wide_addr = {BANK_ZERO, ptr_data} + idx_y;
      MODE_DIR_IDX_IND_X:
        wide_addr = {BANK_ZERO, regs_q.data_bank_base, ptr_data[15:0]};
      MODE_DIR_IND: wide_addr = {BANK_ZERO, regs_q.data_bank_base, ptr_data[15:0]};
      MODE_DIR_IND_LONG: wide_addr = {BANK_ZERO, ptr_data};
      MODE_ABS_X: begin
        wide_addr    = {BANK_ZERO, regs_q.data_bank_base, req_q.byte3, req_q.byte2} + idx_x;
        res_d.length = LEN_THREE;
      end
      MODE_ABS_Y: begin
        wide_addr    = {BANK_ZERO, regs_q.data_bank_base, req_q.byte3, req_q.byte2} + idx_y;
        res_d.length = LEN_THREE;
      end
      MODE_ABS_LONG_X: begin
        wide_addr    = {BANK_ZERO, req_q.byte4, req_q.byte3, req_q.byte2} + idx_x;
        res_d.length = LEN_FOUR;
      end
      MODE_REL: begin
        // Bank stays put: the sum wraps inside 16 bits
        res_d.pc_load  = 1'b1;
        res_d.pc_value = regs_q.pc_next + {{8{req_q.byte2[7]}}, req_q.byte2};
        wide_addr      = {BANK_ZERO, regs_q.program_bank_base, res_d.pc_value};
      end
      MODE_REL_LONG: begin
        res_d.length = LEN_THREE;
        if (req_q.push_rel) begin
          res_d.push_valid = 1'b1;
          res_d.push_value = regs_q.pc_next + {req_q.byte3, req_q.byte2};
        end else begin
          res_d.pc_load  = 1'b1;
          res_d.pc_value = regs_q.pc_next + {req_q.byte3, req_q.byte2};
          wide_addr      = {BANK_ZERO, regs_q.program_bank_base, res_d.pc_value};
        end
      end
      MODE_ABS_IND, MODE_ABS_IDX_IND: begin
        res_d.pc_load  = 1'b1;
        res_d.pc_value = ptr_data[15:0];
        res_d.length   = LEN_THREE;
        wide_addr      = {BANK_ZERO, regs_q.program_bank_base, ptr_data[15:0]};
      end
      MODE_ABS_IND_LONG: begin
        res_d.pc_load     = 1'b1;
        res_d.pc_value    = ptr_data[15:0];
        res_d.pbank_load  = 1'b1;
        res_d.pbank_value = ptr_data[23:16];
        res_d.length      = LEN_THREE;
        wide_addr         = {BANK_ZERO, ptr_data};
      end
    endcase
    // Only the native starred modes keep the top byte
    res_d.addr = (starred && req_q.native) ? wide_addr : (wide_addr & ADDR24_MASK);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_q   <= '0;
      addr_bus_q <= 24'h000000;
    end else if (clk_en) begin
      if (state_q == S_FINISH) begin
        result_q   <= res_d;
        // Top address byte has no pin on the packaged part
        addr_bus_q <= res_d.addr[23:0];
      end else begin
        result_q.valid <= 1'b0;
      end
    end
  end

  assign req_ready  = ready_q;
  assign result     = result_q;
  assign addr_bus   = addr_bus_q;
  assign dp_penalty = penalty_q;

  logic dir_fast_start;
  assign dir_fast_start = accept && state_q == S_IDLE && req.mode == MODE_DIR;

  direct_penalty_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    dir_fast_start && regs.direct_base[7:0] != DL_ZERO && clk_en |=>
      state_q == S_PENALTY ##1 state_q == S_FINISH ##1 result.valid)
    else $error("direct mode did not add one cycle");
  direct_nopenalty_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    dir_fast_start && regs.direct_base[7:0] == DL_ZERO && clk_en |=> ##1 result.valid)
    else $error("direct mode took an extra cycle");
  direct_bank_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    result.valid && req_q.mode inside {MODE_DIR, MODE_DIR_X, MODE_DIR_Y} |->
      result.addr[31:16] == HALF_ZERO)
    else $error("direct address left bank zero");
  absolute_addr_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    result.valid && req_q.mode == MODE_ABS |->
      result.addr == {BANK_ZERO, regs_q.data_bank_base, req_q.byte3, req_q.byte2})
    else $error("absolute address wrong");
  one_byte_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    result.valid && req_q.mode inside {MODE_ACC, MODE_IMPL} |-> result.length == LEN_ONE)
    else $error("accumulator or implied length not one");
  short_branch_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    result.valid && req_q.mode == MODE_REL |-> result.pc_load &&
      result.pc_value == 16'(regs_q.pc_next + {{8{req_q.byte2[7]}}, req_q.byte2}) &&
      !result.pbank_load)
    else $error("short branch target wrong");
  long_rel_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    result.valid && req_q.mode == MODE_REL_LONG |->
      result.push_valid == req_q.push_rel && result.pc_load == !req_q.push_rel)
    else $error("long relative result routed wrongly");
  narrow_addr_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    result.valid && !req_q.native |-> result.addr[31:24] == BANK_ZERO)
    else $error("emulation address wider than 24 bits");
  bus_match_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    result.valid |-> addr_bus == result.addr[23:0])
    else $error("address bus differs from result");
  long_jump_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    result.valid && req_q.mode == MODE_ABS_IND_LONG |->
      result.pbank_load && result.pbank_value == ptr_data[23:16])
    else $error("long jump bank not loaded");

  cover_penalty_c: cover property (@(posedge core_clk) disable iff (sys_rst) penalty_q);
  cover_ptr_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    result.valid && req_q.mode == MODE_DIR_IND_LONG_IDX_Y);
  cover_native_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    result.valid && result.addr[31:24] != BANK_ZERO);

endmodule

// *** bench/mem_model.sv ***
// Pointer memory model standing on the far side of the address generator.
// Assumes the requester holds mem_rd_req and mem_rd_addr until each ack.
`timescale 1ns/100ps
module mem_model (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        slow,
  input  wire logic        mem_rd_req,
  input  wire logic [23:0] mem_rd_addr,
  output logic [7:0]       mem_rd_data,
  output logic             mem_rd_ack
);
  logic [1:0] wait_q;
  // Data toggles outside ack so a stale byte is never taken for a fresh one
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_rd_ack  <= 1'h0;
      mem_rd_data <= 8'h00;
      wait_q      <= 2'h0;
    end else if (mem_rd_req && !mem_rd_ack && wait_q >= {slow, 1'h0}) begin
      mem_rd_ack  <= 1'h1;
      mem_rd_data <= mem_rd_addr[7:0] ^ 8'hC3;
      wait_q      <= 2'h0;
    end else begin
      mem_rd_ack  <= 1'h0;
      mem_rd_data <= ~mem_rd_data;
      wait_q      <= (mem_rd_req && !mem_rd_ack) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule

// *** bench/test_effective_address_generator.sv ***
// Self-checking bench of the effective address generator.
// Assumes a pointer memory model answering on core_clk, prompt or slow.
`timescale 1ns/100ps
module test_effective_address_generator
  import eag_pkg::*;
;
  logic        core_clk, sys_rst, clk_en, slow, pen;
  ea_req_t     req;
  cpu_regs_t   regs;
  logic        req_ready, mem_rd_req, mem_rd_ack, dp_penalty;
  logic [7:0]  mem_rd_data;
  logic [23:0] mem_rd_addr, addr_bus;
  ea_result_t  result;
  int          failures, check_count, lat;

  effective_address_generator i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .req(req),
    .regs(regs), .req_ready(req_ready), .mem_rd_data(mem_rd_data),
    .mem_rd_ack(mem_rd_ack), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
    .result(result), .addr_bus(addr_bus), .dp_penalty(dp_penalty));

  mem_model i_mem (
    .core_clk(core_clk), .sys_rst(sys_rst), .slow(slow), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .mem_rd_ack(mem_rd_ack));

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, s, e);
    end
  endtask

  // One request, held until accepted; lat counts edges from accept to result
  task automatic go(input addr_mode_t m, input logic [31:0] b,
                    input op_size_t s = OPSZ_8, input logic nat = 1'h0,
                    input logic psh = 1'h0);
    int n;
    n = 0;
    while (req_ready !== 1'h1 && n < 50) begin
      @(posedge core_clk); #1;
      n++;
    end
    if (req_ready !== 1'h1) begin
      failures++;
      $display("Error %0t: never ready", $time);
      end_of_test();
    end
    req = '{1'h1, m, s, nat, psh, b[7:0], b[15:8], b[23:16], b[31:24]};
    @(posedge core_clk); #1;
    req.valid = 1'h0;
    lat = 0;
    pen = 1'h0;
    do begin
      @(posedge core_clk); #1;
      lat++;
      pen |= dp_penalty;
    end while (result.valid !== 1'h1 && lat < 50);
    if (result.valid !== 1'h1) begin
      failures++;
      $display("Error %0t: no result", $time);
      end_of_test();
    end
  endtask

  task automatic ea(input logic [31:0] e);
    chk(result.addr, e);
    chk({8'h00, addr_bus}, e & ADDR24_MASK);
  endtask

  task automatic t_imm();
    go(MODE_IMM, 32'h4433_2211);
    chk(result.imm[7:0], 8'h11);
    chk(result.length, LEN_TWO);
    go(MODE_IMM, 32'h4433_2211, OPSZ_16);
    chk(result.imm[15:0], 16'h2211);
    chk(result.length, LEN_THREE);
    go(MODE_IMM, 32'h4433_2211, OPSZ_32);
    chk(result.imm, 32'h4433_2211);
    chk(result.length, LEN_FIVE);
    chk(result.src, SRC_IMMEDIATE);
    $display("immediate done");
  endtask

  task automatic t_short();
    go(MODE_ACC, 32'h0);
    chk(result.length, LEN_ONE);
    chk(result.src, SRC_ACCUM);
    go(MODE_IMPL, 32'h0);
    chk(result.length, LEN_ONE);
    chk(result.src, SRC_IMPLIED);
    // Enable low must freeze a request between accept and result
    req = '{1'h1, MODE_ABS, OPSZ_8, 1'h0, 1'h0, 8'h34, 8'h12, 8'h00, 8'h00};
    @(posedge core_clk); #1;
    req.valid = 1'h0;
    clk_en = 1'h0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(result.valid, 1'h0);
    chk(req_ready, 1'h0);
    clk_en = 1'h1;
    @(posedge core_clk); #1;
    chk(result.valid, 1'h1);
    ea(32'h007E_1234);
    $display("one byte done");
  endtask

  task automatic t_abs();
    go(MODE_ABS, 32'h1234);
    ea(32'h007E_1234);
    go(MODE_ABS_LONG, 32'h0056_1234);
    ea(32'h0056_1234);
    go(MODE_ABS_X, 32'h1234);
    ea(32'h007E_1384);
    go(MODE_ABS_Y, 32'h1234);
    ea(32'h007F_1224);
    regs.index_x = 32'h0100_0010;
    go(MODE_ABS_LONG_X, 32'h0056_1234, OPSZ_8, 1'h1);
    ea(32'h0156_1244);
    regs.index_x = 32'h0000_0150;
    $display("absolute done");
  endtask

  task automatic t_dir();
    go(MODE_DIR, 32'h40);
    ea(32'h0000_1240);
    chk(lat, 1);
    chk(pen, 1'h0);
    go(MODE_DIR_X, 32'h40);
    ea(32'h0000_1390);
    go(MODE_DIR_Y, 32'h40);
    ea(32'h0000_1230);
    // Unaligned base that also wraps past the top of bank zero
    regs.direct_base = 16'hFFF0;
    go(MODE_DIR, 32'h40);
    ea(32'h0000_0030);
    chk(lat, 2);
    chk(pen, 1'h1);
    regs.direct_base = 16'h1200;
    $display("direct done");
  endtask

  task automatic t_ind();
    slow = 1'h1;
    go(MODE_DIR_IND, 32'h40);
    ea(32'h007E_8283);
    chk(lat, 11);
    go(MODE_DIR_IND_LONG, 32'h40);
    ea(32'h0081_8283);
    go(MODE_DIR_IND_IDX_Y, 32'h40);
    ea(32'h007F_8273);
    go(MODE_DIR_IDX_IND_X, 32'h40);
    ea(32'h007E_5253);
    regs.index_y = 32'h0200_0000;
    go(MODE_DIR_IND_LONG_IDX_Y, 32'h40, OPSZ_8, 1'h1);
    ea(32'h0281_8283);
    regs.index_y = 32'h0000_FFF0;
    // Unaligned base: the penalty cycle must come ahead of the pointer reads
    regs.direct_base = 16'h1210;
    go(MODE_DIR_IND, 32'h30);
    ea(32'h007E_8283);
    chk(lat, 12);
    chk(pen, 1'h1);
    regs.direct_base = 16'h1200;
    slow = 1'h0;
    $display("indirect done");
  endtask

  task automatic t_jump();
    go(MODE_REL, 32'h80);
    chk({result.pc_load, result.pc_value}, 17'h1_7F80);
    chk(result.pbank_load, 1'h0);
    go(MODE_REL, 32'h7F);
    chk(result.pc_value, 16'h807F);
    go(MODE_REL_LONG, 32'h8000);
    chk({result.pc_load, result.pc_value}, 17'h1_0000);
    go(MODE_REL_LONG, 32'h7FFF, OPSZ_8, 1'h0, 1'h1);
    chk({result.push_valid, result.push_value}, 17'h1_FFFF);
    chk(result.pc_load, 1'h0);
    go(MODE_ABS_IND, 32'h1234);
    chk({result.pc_load, result.pc_value}, 17'h1_F6F7);
    chk(result.pbank_load, 1'h0);
    go(MODE_ABS_IND_LONG, 32'h1234);
    chk(result.pc_value, 16'hF6F7);
    chk({result.pbank_load, result.pbank_value}, 9'h1F5);
    go(MODE_ABS_IDX_IND, 32'h1234);
    chk({result.pc_load, result.pc_value}, 17'h1_4647);
    chk(result.pbank_load, 1'h0);
    $display("jump done");
  endtask

  initial begin
    failures = 0;
    check_count = 0;
    sys_rst = 1'h1;
    clk_en = 1'h1;
    slow = 1'h0;
    req = '0;
    regs = '{16'h1200, 8'h7E, 8'h03, 16'h8000, 32'h0000_0150, 32'h0000_FFF0};
    repeat (10) @(posedge core_clk);
    #1;
    chk(req_ready, 1'h1);
    chk(result.valid, 1'h0);
    sys_rst = 1'h0;
    @(posedge core_clk); #1;
    t_imm();
    t_short();
    t_abs();
    t_dir();
    t_ind();
    t_jump();
    end_of_test();
  end
endmodule
